// ---- hdl/tss_params.svh ----
// Register map, field positions, reset values and timing counts.
`ifndef TSS_PARAMS_SVH
`define TSS_PARAMS_SVH

// Register byte offsets.
`define TSS_OFS_POLARITY 8'h00
`define TSS_OFS_MODE 8'h04
`define TSS_OFS_BAUD 8'h08
`define TSS_OFS_LENGTH 8'h0c
`define TSS_OFS_REMAIN 8'h10
`define TSS_OFS_DATA 8'h14
`define TSS_OFS_SERVICE 8'h18
`define TSS_OFS_IRQ_STATUS 8'h1c
`define TSS_OFS_IRQ_CLEAR 8'h20
`define TSS_OFS_IRQ_ENABLE 8'h24

// Field positions.
`define TSS_MODE_DIR_BIT 0
`define TSS_MODE_SEQ_LSB 1
`define TSS_MODE_SEQ_MSB 2
`define TSS_SVC_BUSY_BIT 2
`define TSS_IRQ_DONE_BIT 0

// Encodings.
`define TSS_POL_FALLING 9'h08d
`define TSS_POL_RISING 9'h08e
`define TSS_SVC_START 2'h3

// Reset values.
`define TSS_RST_POLARITY 9'h08d
`define TSS_RST_BAUD 16'h0001
`define TSS_RST_LENGTH 16'h0010

// Timing.
`define TSS_MCLK_PERIOD_NS 5
`define TSS_TIMEBASE_NS 240
`define TSS_TIMEBASE_CYCLES (`TSS_TIMEBASE_NS / `TSS_MCLK_PERIOD_NS)
`define TSS_BAUD_MAX 16'h8000

`endif

// ---- hdl/tss_pkg.sv ----
// Types shared by the timer serial shifter.
package tss_pkg;

  // Host sequence modes.
  typedef enum logic [1:0] {
    TSS_SEQ_CLOCK_ONLY = 2'h0,
    TSS_SEQ_OUTPUT = 2'h1,
    TSS_SEQ_INPUT = 2'h2,
    TSS_SEQ_BIDIR = 2'h3
  } tss_seq_t;

  // Transfer setup latched when a transfer starts.
  typedef struct packed {
    logic rising;
    logic msb_first;
    logic out_on;
    logic in_on;
    logic [15:0] half_ticks;
  } tss_cfg_t;

endpackage : tss_pkg

// ---- hdl/tss_shifter.sv ----
// Timer serial shifter: serial clock, shift register and APB registers.
//
// Behaviour
// - 0x08d falling-edge valid, 0x08e rising-edge valid
// - Direction zero LSB first, one MSB first
// - Each clock phase lasts programmed timebase ticks, zero taken as one, capped at 0x8000
// - Copy length to counter, decrement, interrupt
// - Counter loaded from full 16-bit length
// - Out at one end, in at other
// - Output-only shifts zeros; clock-only still shifts
// - No realignment of shift data
// - Transfer runs alone, interrupt when finished
// - Drive after edge, sample after opposite
// - Sequence 00 clock, 01 out, 10 in, 11 both
`timescale 1ns/10ps
`default_nettype none
`include "tss_params.svh"

module tss_shifter
  import tss_pkg::*;
#(
  parameter int TIMEBASE_CYCLES = `TSS_TIMEBASE_CYCLES
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic reset,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Serial link.
  output logic serial_clk,
  output logic serial_out,
  input wire logic serial_in,
  // Interrupt.
  output logic irq
);

  if (TIMEBASE_CYCLES < 1 || TIMEBASE_CYCLES > 65536) begin : g_bad_tb
    $error("TIMEBASE_CYCLES must lie between 1 and 65536");
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] zext16(input logic [15:0] v);
    zext16 = {16'h0000, v};
  endfunction : zext16

  // Zero is treated as one tick so the clock never stalls.
  function automatic logic [15:0] clamp_ticks(input logic [15:0] v);
    if (v == 16'h0000) begin
      clamp_ticks = 16'h0001;
    end else if (v > `TSS_BAUD_MAX) begin
      clamp_ticks = `TSS_BAUD_MAX;
    end else begin
      clamp_ticks = v;
    end
  endfunction : clamp_ticks

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TSS_IDLE,
    TSS_LEAD,
    TSS_TRAIL
  } tss_state_t;

  tss_state_t state;
  tss_cfg_t cfg;
  logic [8:0] clock_polarity_config;
  logic shift_direction;
  logic [1:0] host_sequence_bits;
  logic [15:0] baud_half_cycle_ticks;
  logic [15:0] transfer_length;
  logic [15:0] bits_remaining;
  logic [15:0] shift_data;
  logic irq_status;
  logic irq_enable;
  logic [15:0] tick_count;
  logic [15:0] phase_ticks;
  logic in_meta;
  logic in_sync;
  logic in_bit;

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire logic wr_en = psel & penable & pwrite;
  wire logic hit_pol = paddr == `TSS_OFS_POLARITY;
  wire logic hit_mode = paddr == `TSS_OFS_MODE;
  wire logic hit_baud = paddr == `TSS_OFS_BAUD;
  wire logic hit_len = paddr == `TSS_OFS_LENGTH;
  wire logic hit_rem = paddr == `TSS_OFS_REMAIN;
  wire logic hit_data = paddr == `TSS_OFS_DATA;
  wire logic hit_svc = paddr == `TSS_OFS_SERVICE;
  wire logic hit_ist = paddr == `TSS_OFS_IRQ_STATUS;
  wire logic hit_icl = paddr == `TSS_OFS_IRQ_CLEAR;
  wire logic hit_ien = paddr == `TSS_OFS_IRQ_ENABLE;
  wire logic hit_any = hit_pol | hit_mode | hit_baud | hit_len |
                       hit_rem | hit_data | hit_svc | hit_ist |
                       hit_icl | hit_ien;
  wire logic busy = state != TSS_IDLE;
  wire logic start = wr_en & hit_svc & ~busy &
                     (pwdata[1:0] == `TSS_SVC_START);
  wire logic irq_clear = wr_en & hit_icl &
                         pwdata[`TSS_IRQ_DONE_BIT];

  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  wire logic [31:0] mode_word = {29'h0, host_sequence_bits,
                                 shift_direction};
  wire logic [31:0] svc_word = {29'h0, busy, 2'h0};
  wire logic [31:0] rd_word =
    hit_pol ? {23'h0, clock_polarity_config} :
    hit_mode ? mode_word :
    hit_baud ? zext16(baud_half_cycle_ticks) :
    hit_len ? zext16(transfer_length) :
    hit_rem ? zext16(bits_remaining) :
    hit_data ? zext16(shift_data) :
    hit_svc ? svc_word :
    hit_ist ? {31'h0, irq_status} :
    hit_ien ? {31'h0, irq_enable} : 32'h0000_0000;

  always_ff @(posedge mclk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (psel & ~penable & ~pwrite) begin
      prdata <= rd_word;
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      clock_polarity_config <= `TSS_RST_POLARITY;
      shift_direction <= 1'b0;
      host_sequence_bits <= TSS_SEQ_BIDIR;
      baud_half_cycle_ticks <= `TSS_RST_BAUD;
      transfer_length <= `TSS_RST_LENGTH;
      irq_enable <= 1'b0;
    end else if (wr_en) begin
      if (hit_pol) begin
        clock_polarity_config <= pwdata[8:0];
      end
      if (hit_mode) begin
        shift_direction <= pwdata[`TSS_MODE_DIR_BIT];
        host_sequence_bits <=
          pwdata[`TSS_MODE_SEQ_MSB:`TSS_MODE_SEQ_LSB];
      end
      if (hit_baud) begin
        baud_half_cycle_ticks <= pwdata[15:0];
      end
      if (hit_len) begin
        transfer_length <= pwdata[15:0];
      end
      if (hit_ien) begin
        irq_enable <= pwdata[`TSS_IRQ_DONE_BIT];
      end
    end
  end

  // ----------------------------------------------------------------
  // Timebase and input synchroniser
  // ----------------------------------------------------------------
  wire logic tick = tick_count == 16'(TIMEBASE_CYCLES - 1);

  always_ff @(posedge mclk) begin
    if (reset) begin
      tick_count <= 16'h0000;
    end else if (tick | ~busy) begin
      tick_count <= 16'h0000;
    end else begin
      tick_count <= tick_count + 16'h0001;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      in_meta <= 1'b0;
      in_sync <= 1'b0;
    end else begin
      in_meta <= serial_in;
      in_sync <= in_meta;
    end
  end

  // ----------------------------------------------------------------
  // Transfer sequencer
  // ----------------------------------------------------------------
  // Polarity and sequence are frozen at start, so register writes
  // during a transfer cannot glitch the clock.
  wire logic pol_rising =
    clock_polarity_config == `TSS_POL_RISING;
  wire logic phase_end = tick & (phase_ticks == cfg.half_ticks);
  wire logic lead_edge = (state == TSS_LEAD) & phase_end;
  wire logic trail_edge = (state == TSS_TRAIL) & phase_end;
  wire logic last_bit = bits_remaining == 16'h0001;
  wire logic empty_len = transfer_length == 16'h0000;
  wire logic fill_bit = cfg.in_on & in_bit;
  wire logic [15:0] next_shift = cfg.msb_first ?
    {shift_data[14:0], fill_bit} :
    {fill_bit, shift_data[15:1]};
  wire logic next_out = cfg.msb_first ? next_shift[15] : next_shift[0];
  wire logic first_out = shift_direction ? shift_data[15] :
                                           shift_data[0];
  wire logic done = trail_edge & last_bit;

  always_ff @(posedge mclk) begin
    if (reset) begin
      state <= TSS_IDLE;
      cfg <= '0;
      phase_ticks <= 16'h0001;
      bits_remaining <= 16'h0000;
    end else begin
      case (state)
        TSS_IDLE: begin
          if (start & ~empty_len) begin
            state <= TSS_LEAD;
            cfg.rising <= pol_rising;
            cfg.msb_first <= shift_direction;
            cfg.out_on <= host_sequence_bits[0];
            cfg.in_on <= host_sequence_bits[1];
            cfg.half_ticks <= clamp_ticks(baud_half_cycle_ticks);
            bits_remaining <= transfer_length;
            phase_ticks <= 16'h0001;
          end
        end
        TSS_LEAD: begin
          if (lead_edge) begin
            state <= TSS_TRAIL;
            phase_ticks <= 16'h0001;
          end else if (tick) begin
            phase_ticks <= phase_ticks + 16'h0001;
          end
        end
        TSS_TRAIL: begin
          if (trail_edge) begin
            bits_remaining <= bits_remaining - 16'h0001;
            phase_ticks <= 16'h0001;
            state <= last_bit ? TSS_IDLE : TSS_LEAD;
          end else if (tick) begin
            phase_ticks <= phase_ticks + 16'h0001;
          end
        end
        default: begin
          state <= TSS_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Shift register and serial pins
  // ----------------------------------------------------------------
  // Input passes a two-flop synchroniser, is captured on the valid edge and
  // entered at the shift edge, one clock phase later; the synchroniser and
  // that register stage together make up the servicing delay of this block.
  always_ff @(posedge mclk) begin
    if (reset) begin
      in_bit <= 1'b0;
    end else if (lead_edge) begin
      in_bit <= in_sync;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      shift_data <= 16'h0000;
    end else if (trail_edge) begin
      shift_data <= next_shift;
    end else if (wr_en & hit_data & ~busy) begin
      shift_data <= pwdata[15:0];
    end
  end

  // Idle level is the one before the valid edge: low for rising.
  always_ff @(posedge mclk) begin
    if (reset) begin
      serial_clk <= 1'b0;
    end else if (state == TSS_IDLE) begin
      serial_clk <= ~pol_rising;
    end else if (lead_edge) begin
      serial_clk <= cfg.rising;
    end else if (trail_edge) begin
      serial_clk <= ~cfg.rising;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      serial_out <= 1'b0;
    end else if (start & host_sequence_bits[0]) begin
      serial_out <= first_out;
    end else if (trail_edge & ~last_bit & cfg.out_on) begin
      serial_out <= next_out;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt
  // ----------------------------------------------------------------
  wire logic done_event = done | (start & empty_len);

  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_status <= 1'b0;
    end else if (done_event) begin
      irq_status <= 1'b1;
    end else if (irq_clear) begin
      irq_status <= 1'b0;
    end
  end

  assign irq = irq_status & irq_enable;

endmodule : tss_shifter
`default_nettype wire

// ---- test/tss_monitor.sv ----
// Port checker for the timer serial shifter.
`timescale 1ns/10ps
`default_nettype none
module tss_monitor (
  // Clock, reset and APB.
  input wire logic mclk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Link and interrupt.
  input wire logic serial_clk,
  input wire logic serial_out,
  input wire logic serial_in,
  input wire logic irq
);
  wire logic acc = psel && penable;
  wire logic wr = acc && pwrite;
  wire logic unm = paddr > 8'h24 || paddr[1:0] != 2'h0;
  logic pend_rise;
  logic cur_rise;
  wire logic idle_lvl = ~cur_rise;
  // Rest level for the code of the last start; new codes move the pin early.
  always_ff @(posedge mclk) begin
    if (reset) begin
      pend_rise <= 1'b0;
      cur_rise <= 1'b0;
    end else begin
      if (wr && paddr == 8'h00) pend_rise <= pwdata[8:0] == 9'h08e;
      if (wr && paddr == 8'h18 && pwdata[1:0] == 2'h3) cur_rise <= pend_rise;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_lead;
    $changed(serial_clk) && serial_clk != idle_lvl;
  endsequence
  AST_APB_READY: assert property (acc |-> pready)
    else $error("pready low in access");
  AST_APB_ERR: assert property (acc && unm |-> pslverr && (pwrite || !prdata))
    else $error("unmapped access not refused");
  AST_APB_OK: assert property (acc && !unm |-> !pslverr)
    else $error("mapped access refused");
  AST_ERR_IDLE: assert property (!acc |-> !pslverr)
    else $error("pslverr outside access");
  AST_CLK_HALF: assert property (s_lead |=> $stable(serial_clk))
    else $error("clock phase too short");
  AST_OUT_AT_IDLE: assert property (
    $changed(serial_out) |-> !serial_clk == cur_rise)
    else $error("data moved off trailing edge");
  AST_IRQ_FALL: assert property (
    $fell(irq) |-> $past(wr && (paddr == 8'h20 && pwdata[0] ||
      paddr == 8'h24 && !pwdata[0])))
    else $error("irq dropped without clear");
  AST_IRQ_RISE: assert property (
    $rose(irq) |-> serial_clk == idle_lvl)
    else $error("irq raised mid bit");
  AST_IRQ_MASK: assert property (wr && paddr == 8'h24 && !pwdata[0] |=> !irq)
    else $error("masked irq high");
endmodule : tss_monitor
bind tss_shifter tss_monitor mon (.mclk(mclk), .reset(reset), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serial_clk(serial_clk), .serial_out(serial_out), .serial_in(serial_in),
  .irq(irq));
`default_nettype wire

// ---- test/tss_peripheral.sv ----
// Serial peripheral model on the far side of the link.
`timescale 1ns/10ps
`default_nettype none
module tss_peripheral (
  // Setup from the bench.
  input wire logic mclk,
  input wire logic load,
  input wire logic [15:0] tx_word,
  input wire logic [15:0] len,
  input wire logic msb_first,
  input wire logic rising,
  // Link.
  input wire logic serial_clk,
  input wire logic serial_out,
  output logic serial_in,
  output logic [15:0] rx_word
);
  logic last_clk = 1'b0;
  logic [15:0] cnt = 16'h0;
  wire logic moved = serial_clk != last_clk;
  wire logic lead = moved && serial_clk == rising;
  wire logic live = cnt < len && cnt < 16'h10;
  wire logic [3:0] idx = msb_first ? 4'hf - cnt[3:0] : cnt[3:0];
  always @(posedge mclk) begin
    last_clk <= serial_clk;
    if (load) begin
      cnt <= 16'h0;
      rx_word <= 16'h0;
      serial_in <= msb_first ? tx_word[15] : tx_word[0];
    end else if (lead) begin
      cnt <= cnt + 16'h1;
      rx_word <= msb_first ? {rx_word[14:0], serial_out} :
                             {serial_out, rx_word[15:1]};
    end else if (moved && live) begin
      // Data only moves on the trailing edge, so it is held past sampling.
      serial_in <= tx_word[idx];
    end else if (!live && serial_clk != rising) begin
      // Outside its bits the line carries noise, never a stale bit.
      serial_in <= ~serial_in;
    end
  end
endmodule : tss_peripheral
`default_nettype wire

// ---- test/tb_top.sv ----
// Self-checking testbench for the timer serial shifter.
`timescale 1ns/10ps
`default_nettype none
`include "tss_params.svh"
module tb_top;
  import tss_pkg::*;
  localparam int TB = 2;
  logic mclk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, serial_clk, serial_out, serial_in, irq, er;
  logic load = 1'b0, msb = 1'b0, rise = 1'b0, prev_clk = 1'b0, was_lead = 1'b0;
  logic [15:0] tx = 16'h0, len = 16'h0, rx, n;
  logic [7:0] ra [4] = '{`TSS_OFS_POLARITY, `TSS_OFS_MODE, `TSS_OFS_BAUD,
    `TSS_OFS_LENGTH};
  logic [31:0] rv [4] = '{32'h8d, 32'h6, 32'h1, 32'h10};
  int num_errors = 0, num_checks = 0, leads = 0, half = 0, exp_half = 0;
  int cyc = 0;
  tss_shifter #(.TIMEBASE_CYCLES(TB)) dut (.mclk(mclk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_clk(serial_clk), .serial_out(serial_out), .serial_in(serial_in),
    .irq(irq));
  tss_peripheral peer (.mclk(mclk), .load(load), .tx_word(tx), .len(len),
    .msb_first(msb), .rising(rise), .serial_clk(serial_clk),
    .serial_out(serial_out), .serial_in(serial_in), .rx_word(rx));
  initial forever #2.5 mclk = ~mclk;
  task automatic end_sim;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Shifts d n times, feeding bits of w in send order when on is set.
  function automatic logic [15:0] sh(input logic [15:0] d,
      input logic [15:0] w, input logic m, input int n, input logic on);
    logic b;
    for (int k = 0; k < n; k++) begin
      b = on ? (m ? w[15 - k] : w[k]) : 1'b0;
      d = m ? {d[14:0], b} : {b, d[15:1]};
    end
    return d;
  endfunction : sh
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    half <= half + 1;
    prev_clk <= serial_clk;
    if (serial_clk !== prev_clk) begin
      half <= 1;
      was_lead <= serial_clk === rise;
      if (serial_clk === rise) begin
        leads <= leads + 1;
        // Only leads inside a transfer close a trail phase worth timing.
        if (leads > 0 && leads < len) chk("trail", exp_half, half);
      end else if (was_lead) chk("half", exp_half, half);
    end
    if (cyc == 20000) begin
      num_errors++;
      end_sim;
    end
  end
  task automatic xfer(input logic [1:0] sq, input logic m, input logic r,
      input logic [15:0] n, input logic [15:0] b);
    logic [15:0] d;
    logic [15:0] t;
    d = 16'($urandom);
    t = 16'($urandom);
    apb(1'b1, `TSS_OFS_IRQ_CLEAR, 32'h1);
    apb(1'b1, `TSS_OFS_POLARITY, r ? 32'h8e : 32'h8d);
    apb(1'b1, `TSS_OFS_MODE, {29'h0, sq, m});
    apb(1'b1, `TSS_OFS_BAUD, {16'h0, b});
    apb(1'b1, `TSS_OFS_LENGTH, {16'h0, n});
    apb(1'b1, `TSS_OFS_DATA, {16'h0, d});
    chk("irq", 32'h0, {31'h0, irq});
    tx <= t;
    len <= n;
    msb <= m;
    rise <= r;
    load <= 1'b1;
    @(posedge mclk);
    load <= 1'b0;
    exp_half = b * TB;
    leads = 0;
    apb(1'b1, `TSS_OFS_SERVICE, 32'h3);
    apb(1'b1, `TSS_OFS_SERVICE, 32'h3);
    apb(1'b1, `TSS_OFS_DATA, 32'hffff);
    apb(1'b0, `TSS_OFS_SERVICE, 32'h0);
    chk("busy", 32'h1 << `TSS_SVC_BUSY_BIT, rd);
    for (int i = 0; i < 9000 && irq !== 1'b1; i++) @(posedge mclk);
    chk("done", 32'h1, {31'h0, irq});
    chk("clocks", {16'h0, n}, leads);
    apb(1'b0, `TSS_OFS_REMAIN, 32'h0);
    chk("remain", 32'h0, rd);
    apb(1'b0, `TSS_OFS_SERVICE, 32'h0);
    chk("idle", 32'h0, rd);
    apb(1'b0, `TSS_OFS_DATA, 32'h0);
    chk("data", {16'h0, sh(d, t, m, n, sq[1])}, rd);
    if (sq[0]) chk("rx", {16'h0, sh(16'h0, d, m, n, 1'b1)},
        {16'h0, rx});
  endtask : xfer
  initial begin
    void'($urandom(84129));
    repeat (5) @(posedge mclk);
    reset <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk("reset", rv[i], rd);
    end
    apb(1'b1, 8'h28, 32'hffff_ffff);
    chk("slverr", 32'h1, {31'h0, er});
    apb(1'b0, 8'h28, 32'h0);
    chk("unmapped", 32'h0, rd);
    apb(1'b1, `TSS_OFS_LENGTH, 32'h0);
    leads = 0;
    apb(1'b1, `TSS_OFS_SERVICE, 32'h3);
    apb(1'b0, `TSS_OFS_IRQ_STATUS, 32'h0);
    chk("status", 32'h1, rd);
    chk("irq", 32'h0, {31'h0, irq});
    apb(1'b1, `TSS_OFS_IRQ_ENABLE, 32'h1);
    @(posedge mclk);
    chk("irq", 32'h1, {31'h0, irq});
    chk("clocks", 32'h0, leads);
    apb(1'b1, `TSS_OFS_IRQ_ENABLE, 32'h0);
    @(posedge mclk);
    chk("masked", 32'h0, {31'h0, irq});
    apb(1'b1, `TSS_OFS_IRQ_ENABLE, 32'h1);
    for (int i = 0; i < 16; i++) begin
      n = (i == 0) ? 16'h10 : (i == 1) ? 16'h1 : 16'(1 + $urandom % 16);
      xfer(i[1:0], i[2], i[3], n, 16'(3 + $urandom % 2));
    end
    xfer(2'h0, 1'b1, 1'b0, 16'd20, 16'd3);
    end_sim;
  end
endmodule : tb_top
`default_nettype wire
